// ### bench/dfsp_codec_model.sv
/*
 what: behavioural codec acting as clock master toward a slave-mode port
 assumes: 200 ns bit clock, frames started by the bench through send_frame
*/
`timescale 1ns/1ps
module dfsp_codec_model (
   output logic bit_clock,
   output logic word_select,
   output logic serial_data,
   input  wire logic serial_in
);
   // bits heard from the port during the data slots of the last frame
   logic [31:0] heard;
   // clock rests low between frames; the data line has no pull, so it idles inverted
   initial begin
      bit_clock = 1'b0;
      word_select = 1'b0;
      serial_data = 1'b1;
      heard = '0;
   end
   // one slot: values change while the clock is low and hold over its rising edge
   task automatic slot(input logic ws, input logic d);
      word_select = ws;
      serial_data = d;
      #100 bit_clock = 1'b1;
      #100 bit_clock = 1'b0;
   endtask
   // word-select pulse, then left and right msb first, then zero-stuffed clocks
   task automatic send_frame(input logic [15:0] left, input logic [15:0] right);
      logic [31:0] bits;
      bits = {left, right};
      slot(1'b1, 1'b0);
      for (int i = 31; i >= 0; i--) begin
         slot(1'b0, bits[i]);
         // at the falling edge the port still shows the bit for this slot
         heard[i] = serial_in;
      end
      for (int i = 0; i < 8; i++) slot(1'b0, 1'b0);
      serial_data = 1'b1;
   endtask
endmodule // dfsp_codec_model

// ### bench/dfsp_regs_sva.sv
/*
 what: port-level assertions for the serial port register block
 assumes: bound to dfsp_regs; one clock, synchronous active-low reset
*/
`timescale 1ns/1ps
module dfsp_regs_sva
   import dfsp_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        sel,
   input wire logic        enable,
   input wire logic        write,
   input wire logic [16:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [31:0] rdata,
   input wire logic        dma_ack,
   input wire logic        tx_dma_request,
   input wire logic        rx_dma_request,
   input wire logic        bit_clock_out,
   input wire logic        bit_clock_oe,
   input wire logic        word_select_oe,
   input wire logic        audio_port_to_pads,
   input wire logic        two_wire_to_pads,
   input wire logic        codec_reset_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // decoded accesses, one per sel and enable cycle
   wire acc_wr = sel && enable && write;
   wire acc_rd = sel && enable && !write;

   // first edge after release still shows the reset state of the codec line
   a_reset_codec_low: assert property ($rose(reset_n) |-> !codec_reset_n && !bit_clock_oe)
      else $error("codec reset or clock enable not low after reset");
   a_pad_route_follow: assert property (acc_wr && addr == ADDR_PAD_ROUTING |=>
      audio_port_to_pads == $past(wdata[1]) && two_wire_to_pads == $past(wdata[0]))
      else $error("pad routing outputs do not follow the write");
   a_codec_rst_follow: assert property (acc_wr && addr == ADDR_CODEC_RESET |=>
      codec_reset_n == $past(wdata[0])) else $error("codec reset output wrong after write");
   a_ack_drops_req: assert property ($rose(dma_ack) |=> !tx_dma_request && !rx_dma_request)
      else $error("dma request not dropped on acknowledge");
   a_clock_oe_pair: assert property (bit_clock_oe == word_select_oe)
      else $error("bit clock and word select enables differ");
   a_master_clock_runs: assert property ($rose(bit_clock_oe) |-> ##[1:8] $changed(bit_clock_out))
      else $error("generated bit clock does not toggle");
   a_flags_reserved: assert property (acc_rd && addr == ADDR_FIFO_FLAGS |=> rdata[31:2] == '0)
      else $error("status reserved bits not zero");
   a_clear_reads_zero: assert property (acc_rd && addr == ADDR_FIFO_PTR |=> rdata == '0)
      else $error("fifo clear register does not read zero");
   a_rx_low_byte: assert property (acc_rd && addr == ADDR_RX_SAMPLE |=> rdata[7:0] == 8'h00)
      else $error("rx sample reserved byte not zero");

   // main scenarios reached
   c_ack_seen: cover property ($rose(dma_ack) && tx_dma_request);
   c_rx_request: cover property ($rose(rx_dma_request));
   c_master_on: cover property ($rose(bit_clock_oe));
endmodule // dfsp_regs_sva

bind dfsp_regs dfsp_regs_sva u_dfsp_regs_sva (.clk(clk), .reset_n(reset_n), .sel(sel),
   .enable(enable), .write(write), .addr(addr), .wdata(wdata), .rdata(rdata),
   .dma_ack(dma_ack), .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request),
   .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe),
   .word_select_oe(word_select_oe), .audio_port_to_pads(audio_port_to_pads),
   .two_wire_to_pads(two_wire_to_pads), .codec_reset_n(codec_reset_n));

// ### bench/dfsp_regs_tb.sv
/*
 what: self-checking bench for the serial port register block
 assumes: codec model as clock master, 40 MHz clock, no shortened counts
*/
`timescale 1ns/1ps
module dfsp_regs_tb;
   import dfsp_pkg::*;
   logic        clk, reset_n, sel, enable, write, dma_ack, bck, wsel, sdin;
   logic [16:0] addr;
   logic [31:0] wdata, rdata, rd_val, v;
   logic        tx_dma_request, rx_dma_request, bit_clock_oe, word_select_oe;
   logic        audio_port_to_pads, two_wire_to_pads, codec_reset_n, sdout;
   int          err_count, num_checks, cycles;
   // register table: last entry is an unmapped hole; masks are the values read back after the all-ones writes
   localparam logic [16:0] RA [10] = '{ADDR_TX_CONFIG, ADDR_TX_COMMAND, ADDR_FIFO_PTR,
      ADDR_RX_CONFIG, ADDR_RX_COMMAND, ADDR_FIFO_FLAGS, ADDR_RX_SAMPLE, ADDR_PAD_ROUTING,
      ADDR_CODEC_RESET, 17'h1ec04};
   localparam logic [31:0] RM [10] = '{32'h3f, 32'h7, 32'h0, 32'h3f, 32'h3, 32'h1, 32'h0,
      32'h3, 32'h1, 32'h0};

   dfsp_regs u_dfsp_regs (.clk(clk), .reset_n(reset_n), .sel(sel), .enable(enable),
      .write(write), .addr(addr), .wdata(wdata), .rdata(rdata), .dma_ack(dma_ack),
      .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request),
      .bit_clock_in(bck), .word_select_in(wsel), .serial_data_in(sdin),
      .bit_clock_out(), .bit_clock_oe(bit_clock_oe), .word_select_out(),
      .word_select_oe(word_select_oe), .serial_data_out(sdout),
      .audio_port_to_pads(audio_port_to_pads), .two_wire_to_pads(two_wire_to_pads),
      .codec_reset_n(codec_reset_n));
   dfsp_codec_model u_dfsp_codec_model (.bit_clock(bck), .word_select(wsel),
      .serial_data(sdin), .serial_in(sdout));

   // 25 ns clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // the whole run needs about 1000 cycles, so this only trips on a hang
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one access, entered just after an edge; an idle cycle follows so strobes never collide
   task automatic wr(input logic [16:0] a, input logic [31:0] d);
      sel <= 1'b1;
      enable <= 1'b1;
      write <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      sel <= 1'b0;
      enable <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [16:0] a, output logic [31:0] d);
      sel <= 1'b1;
      enable <= 1'b1;
      addr <= a;
      @(posedge clk);
      sel <= 1'b0;
      enable <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
   task automatic rc(input logic [16:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check(d, exp);
   endtask
   task automatic stop_test();
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // main sequence
   initial begin
      reset_n = 1'b0;
      sel = 1'b0;
      enable = 1'b0;
      write = 1'b0;
      dma_ack = 1'b0;
      addr = '0;
      wdata = '0;
      err_count = 0;
      num_checks = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      // reset values, then all-ones and all-zeros through every address in the register table
      for (int i = 0; i < 10; i++) rc(RA[i], {31'h0, i == 5});
      for (int i = 0; i < 10; i++) wr(RA[i], 32'hffffffff);
      for (int i = 0; i < 10; i++) rc(RA[i], RM[i]);
      check({audio_port_to_pads, two_wire_to_pads, codec_reset_n, tx_dma_request}, 4'hf);
      check({bit_clock_oe, rx_dma_request}, 2'b10);
      for (int i = 0; i < 10; i++) wr(RA[i], 32'h0);
      for (int i = 0; i < 10; i++) rc(RA[i], {31'h0, i == 5});
      check({audio_port_to_pads, two_wire_to_pads, codec_reset_n, tx_dma_request}, 4'h0);
      check(bit_clock_oe, 1'b0);
      // every rate code, both roles, every width code in both directions
      for (int i = 0; i < 8; i++) begin
         v = {26'h0, 3'(i), 1'(i), 2'(i)};
         wr(ADDR_TX_CONFIG, v);
         wr(ADDR_RX_CONFIG, v);
         rc(ADDR_TX_CONFIG, v);
         rc(ADDR_RX_CONFIG, v);
      end
      wr(ADDR_TX_CONFIG, 32'h0);
      wr(ADDR_RX_CONFIG, 32'h0);
      // transmit off so nothing drains: fill to eight, refuse, clear
      wr(ADDR_TX_COMMAND, 32'h1);
      for (int i = 0; i < 8; i++) begin
         rc(ADDR_FIFO_FLAGS, 32'h1);
         check(tx_dma_request, 1'b1);
         wr(ADDR_TX_SAMPLE, {8'(i), 24'h0});
      end
      wr(ADDR_TX_SAMPLE, 32'h12345600);
      rc(ADDR_FIFO_FLAGS, 32'h0);
      check(tx_dma_request, 1'b0);
      wr(ADDR_FIFO_PTR, 32'h2);
      rc(ADDR_FIFO_FLAGS, 32'h0);
      wr(ADDR_FIFO_PTR, 32'h1);
      rc(ADDR_FIFO_FLAGS, 32'h1);
      dma_ack <= 1'b1;
      repeat (3) @(posedge clk);
      check(tx_dma_request, 1'b1);
      dma_ack <= 1'b0;
      // slave-role reception: first with receive off, then on with dma enabled
      wr(ADDR_TX_COMMAND, 32'h4);
      wr(ADDR_RX_COMMAND, 32'h1);
      u_dfsp_codec_model.send_frame(16'h1234, 16'h5678);
      repeat (20) @(posedge clk);
      rc(ADDR_FIFO_FLAGS, 32'h1);
      wr(ADDR_RX_COMMAND, 32'h3);
      wr(ADDR_TX_SAMPLE, 32'h9a7b0000);
      wr(ADDR_TX_SAMPLE, 32'h4c1d0000);
      wr(ADDR_TX_COMMAND, 32'h6);
      u_dfsp_codec_model.send_frame(16'ha5c3, 16'h3c5a);
      check(u_dfsp_codec_model.heard, 32'h9a7b4c1d);
      rd_val = '0;
      for (int n = 0; n < 40 && rd_val[1] !== 1'b1; n++) rd(ADDR_FIFO_FLAGS, rd_val);
      check(rx_dma_request, 1'b1);
      rc(ADDR_RX_SAMPLE, 32'ha5c30000);
      rc(ADDR_RX_SAMPLE, 32'h3c5a0000);
      rc(ADDR_FIFO_FLAGS, 32'h1);
      check(rx_dma_request, 1'b0);
      rc(ADDR_RX_SAMPLE, 32'h0);
      // a second reset must pull the released codec back into reset
      wr(ADDR_CODEC_RESET, 32'h1);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      check(codec_reset_n, 1'b0);
      rc(ADDR_FIFO_FLAGS, 32'h1);
      stop_test();
   end
endmodule // dfsp_regs_tb

// ### core/dfsp_pkg.sv
/*
 what: constants for the dsp-format audio serial port register block
 assumes: included by the single design module; offsets are byte addresses
*/
package dfsp_pkg;
   // register byte addresses on the documented register port
   localparam logic [16:0] ADDR_TX_CONFIG   = 17'h1ec00;
   localparam logic [16:0] ADDR_TX_COMMAND  = 17'h1ec08;
   localparam logic [16:0] ADDR_TX_SAMPLE   = 17'h1ec10;
   localparam logic [16:0] ADDR_FIFO_PTR    = 17'h1ec20;
   localparam logic [16:0] ADDR_RX_CONFIG   = 17'h1ec30;
   localparam logic [16:0] ADDR_RX_COMMAND  = 17'h1ec34;
   localparam logic [16:0] ADDR_FIFO_FLAGS  = 17'h1ec38;
   localparam logic [16:0] ADDR_RX_SAMPLE   = 17'h1ec40;
   localparam logic [16:0] ADDR_PAD_ROUTING = 17'h1ec60;
   localparam logic [16:0] ADDR_CODEC_RESET = 17'h1ec64;
   // field positions
   localparam int RATE_HI = 5;
   localparam int RATE_LO = 3;
   localparam int ROLE_BIT = 2;
   localparam int WIDTH_HI = 1;
   localparam int WIDTH_LO = 0;
   localparam int IF_EN_BIT = 2;
   localparam int XFER_EN_BIT = 1;
   localparam int DMA_EN_BIT = 0;
   localparam int RX_CLR_BIT = 1;
   localparam int TX_CLR_BIT = 0;
   localparam int AUDIO_PAD_BIT = 1;
   localparam int TWO_WIRE_PAD_BIT = 0;
   localparam int CODEC_RST_BIT = 0;
   localparam int SAMPLE_HI = 31;
   localparam int SAMPLE_LO = 8;
   localparam int SAMPLE_W = 24;
   // config and command widths
   localparam int CONF_W = 6;
   localparam int CMD_W  = 3;
   // fifo geometry
   localparam int FIFO_DEPTH = 8;
   localparam int PTR_W = 3;
   // sample-rate codes
   typedef enum logic [2:0] {
      DFSP_FS_48K, DFSP_FS_44K1, DFSP_FS_32K, DFSP_FS_22K05,
      DFSP_FS_16K, DFSP_FS_11K025, DFSP_FS_8K, DFSP_FS_8K_ALT
   } dfsp_rate_t;
   // word width codes
   typedef enum logic [1:0] {
      DFSP_W16, DFSP_W18, DFSP_W20, DFSP_W24
   } dfsp_width_t;
   // bit clock aims at the 12 MHz master clock; bit clocks per frame per rate
   localparam int MCLK_HZ = 12000000;
   localparam int CLK_HZ  = 40000000;
   // half-period of the generated bit clock in system cycles (rounded down, min 1)
   localparam int BCLK_HALF_CYC = (CLK_HZ / MCLK_HZ / 2) < 1 ? 1 : CLK_HZ / MCLK_HZ / 2;
   localparam logic [10:0] FRAME_250 = 11'h0fa;
   localparam logic [10:0] FRAME_272 = 11'h110;
endpackage : dfsp_pkg

// ### core/dfsp_regs.sv
/*
 what: register file, tx/rx fifos, dma requests and dsp-format serial engine
 assumes: documented register port (select, enable, write, address, data), one
 40 MHz clock; bit clock and word select from a master-mode codec are
 asynchronous pins sampled here
*/
`timescale 1ns/1ps
// What this block does
// - tx rate field picks 250 or 272 bit clocks per frame
// - rx rate field, stored and read back but unused
// - tx config bit two picks slave or master role
// - bits one-zero pick 16/18/20/24 bits
// - tx command bit two starts interface
// - tx command bit one enables transmit
// - tx command bit zero gates dma requests
// - rx command bit one enables receive
// - rx command bit zero gates dma requests
// - tx buffer takes msb-aligned sample
// - rx buffer returns msb-aligned sample
// - status bit one: rx fifo not empty
// - status bit zero: tx fifo has room
// - routing bit one sends port to pads
// - routing bit zero sends two-wire to pads
// - codec reset bit drives codec reset output
// - reset holds codec reset bit low
// - each direction buffers eight words
// - frame starts after word-select rise, msb first
// - dma request drops on acknowledge rise
// - master drives clocks, slave accepts them
module dfsp_regs
   import dfsp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        sel,
   input  wire logic        enable,
   input  wire logic        write,
   input  wire logic [16:0] addr,
   input  wire logic [31:0] wdata,
   output logic      [31:0] rdata,
   input  wire logic        dma_ack,
   output logic             tx_dma_request,
   output logic             rx_dma_request,
   input  wire logic        bit_clock_in,
   input  wire logic        word_select_in,
   input  wire logic        serial_data_in,
   output logic             bit_clock_out,
   output logic             bit_clock_oe,
   output logic             word_select_out,
   output logic             word_select_oe,
   output logic             serial_data_out,
   output logic             audio_port_to_pads,
   output logic             two_wire_to_pads,
   output logic             codec_reset_n
);
   logic [CONF_W-1:0]   tx_config;
   logic [CMD_W-1:0]    tx_command;
   logic [CONF_W-1:0]   rx_config;
   logic [CMD_W-1:0]    rx_command;
   logic [SAMPLE_W-1:0] tx_mem [FIFO_DEPTH];
   logic [SAMPLE_W-1:0] rx_mem [FIFO_DEPTH];
   logic [PTR_W:0]      tx_wp, tx_rp, rx_wp, rx_rp;
   logic                tx_full, tx_empty, rx_full, rx_empty;
   logic                wr_acc, rd_acc, tx_push, rx_pop, tx_pop, rx_push;
   logic [SAMPLE_W-1:0] rx_word;
   logic [2:0]          bck_s, wsl_s;
   logic [1:0]          sdi_s;
   logic                ack_d;
   logic                bck_int, wsl_int;
   logic [3:0]          div_cnt;
   logic [10:0]         bit_pos;
   logic                bck_now, wsl_now, wsl_prev;
   logic [SAMPLE_W-1:0] tx_shift, rx_shift;
   logic                run;

   // bit mask for a word width: samples shorter than 24 bits keep zeros below lsb
   function automatic logic [SAMPLE_W-1:0] width_mask(input logic [1:0] code);
      unique case (dfsp_width_t'(code))
         DFSP_W16: width_mask = 24'hffff00;
         DFSP_W18: width_mask = 24'hffffc0;
         DFSP_W20: width_mask = 24'hfffff0;
         DFSP_W24: width_mask = 24'hffffff;
      endcase
   endfunction

   // bit clocks per frame; 48k family uses 250, 44.1k family 272
   function automatic logic [10:0] frame_len(input logic [2:0] code);
      unique case (dfsp_rate_t'(code))
         DFSP_FS_44K1, DFSP_FS_22K05, DFSP_FS_11K025: frame_len = FRAME_272;
         default:                                      frame_len = FRAME_250;
      endcase
   endfunction

   // channel length in bits for the configured width
   function automatic logic [4:0] chan_bits(input logic [1:0] code);
      unique case (dfsp_width_t'(code))
         DFSP_W16: chan_bits = 5'h10;
         DFSP_W18: chan_bits = 5'h12;
         DFSP_W20: chan_bits = 5'h14;
         DFSP_W24: chan_bits = 5'h18;
      endcase
   endfunction

   // access decode; one access per sel and enable cycle, so a held enable would
   // repeat a push or a pop once per clock: masters must drop it after one cycle
   // pointers carry one extra wrap bit so that full and empty differ when the
   // low bits match; eight words fill the array exactly
   assign wr_acc  = sel & enable & write;
   assign rd_acc  = sel & enable & ~write;
   assign run     = tx_command[IF_EN_BIT];
   assign tx_push = wr_acc && addr == ADDR_TX_SAMPLE && !tx_full;
   assign rx_pop  = rd_acc && addr == ADDR_RX_SAMPLE && !rx_empty;
   assign tx_full  = (tx_wp[PTR_W] != tx_rp[PTR_W]) && (tx_wp[PTR_W-1:0] == tx_rp[PTR_W-1:0]);
   assign tx_empty = tx_wp == tx_rp;
   assign rx_full  = (rx_wp[PTR_W] != rx_rp[PTR_W]) && (rx_wp[PTR_W-1:0] == rx_rp[PTR_W-1:0]);
   assign rx_empty = rx_wp == rx_rp;

   // configuration and command registers; reserved bits are not stored
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_config  <= '0;
         tx_command <= '0;
         rx_config  <= '0;
         rx_command <= '0;
      end else if (wr_acc) begin
         if (addr == ADDR_TX_CONFIG)  tx_config  <= wdata[CONF_W-1:0];
         if (addr == ADDR_TX_COMMAND) tx_command <= wdata[CMD_W-1:0];
         if (addr == ADDR_RX_CONFIG)  rx_config  <= wdata[CONF_W-1:0];
         if (addr == ADDR_RX_COMMAND) rx_command <= {1'b0, wdata[XFER_EN_BIT:0]};
      end
   end

   // codec reset powers up asserted; software must release it after reset
   // routing and codec reset; codec reset bit forced low by reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         audio_port_to_pads <= 1'b0;
         two_wire_to_pads   <= 1'b0;
         codec_reset_n      <= 1'b0;
      end else if (wr_acc) begin
         if (addr == ADDR_PAD_ROUTING) begin
            audio_port_to_pads <= wdata[AUDIO_PAD_BIT];
            two_wire_to_pads   <= wdata[TWO_WIRE_PAD_BIT];
         end
         if (addr == ADDR_CODEC_RESET) codec_reset_n <= wdata[CODEC_RST_BIT];
      end
   end

   // transmit fifo; a clear write wins over a pop in the same cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_wp <= '0;
         tx_rp <= '0;
      end else if (wr_acc && addr == ADDR_FIFO_PTR && wdata[TX_CLR_BIT]) begin
         tx_wp <= '0;
         tx_rp <= '0;
      end else begin
         if (tx_push) begin
            tx_mem[tx_wp[PTR_W-1:0]] <= wdata[SAMPLE_HI:SAMPLE_LO];
            tx_wp <= tx_wp + 1'b1;
         end
         if (tx_pop) tx_rp <= tx_rp + 1'b1;
      end
   end

   // receive fifo; a word arriving when full is dropped
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_wp <= '0;
         rx_rp <= '0;
      end else if (wr_acc && addr == ADDR_FIFO_PTR && wdata[RX_CLR_BIT]) begin
         rx_wp <= '0;
         rx_rp <= '0;
      end else begin
         if (rx_push && !rx_full) begin
            rx_mem[rx_wp[PTR_W-1:0]] <= rx_word;
            rx_wp <= rx_wp + 1'b1;
         end
         if (rx_pop) rx_rp <= rx_rp + 1'b1;
      end
   end

   // reading the rx buffer when empty returns zero and leaves the pointers
   // alone, so a stray poll cannot lose a word
   // read data mux; unmapped and reserved bits return zero
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata <= '0;
      end else if (rd_acc) begin
         unique case (addr)
            ADDR_TX_CONFIG:   rdata <= {26'h0, tx_config};
            ADDR_TX_COMMAND:  rdata <= {29'h0, tx_command};
            ADDR_RX_CONFIG:   rdata <= {26'h0, rx_config};
            ADDR_RX_COMMAND:  rdata <= {29'h0, rx_command};
            ADDR_FIFO_FLAGS:  rdata <= {30'h0, !rx_empty, !tx_full};
            ADDR_RX_SAMPLE:   rdata <= rx_empty ? 32'h0 :
                                       {rx_mem[rx_rp[PTR_W-1:0]], 8'h00};
            ADDR_PAD_ROUTING: rdata <= {30'h0, audio_port_to_pads, two_wire_to_pads};
            ADDR_CODEC_RESET: rdata <= {31'h0, codec_reset_n};
            default:          rdata <= '0;
         endcase
      end
   end

   // ack_d remembers the acknowledge level so only its rising edge counts; a
   // held acknowledge leaves the requests following the flags again
   // dma requests follow the fifo flags, drop for one cycle on ack rise
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ack_d          <= 1'b0;
         tx_dma_request <= 1'b0;
         rx_dma_request <= 1'b0;
      end else begin
         ack_d          <= dma_ack;
         tx_dma_request <= tx_command[DMA_EN_BIT] && !tx_full && !(dma_ack && !ack_d);
         rx_dma_request <= rx_command[DMA_EN_BIT] && !rx_empty && !(dma_ack && !ack_d);
      end
   end

   // pin synchronisers; stage zero feeds only stage one
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bck_s <= '0;
         wsl_s <= '0;
         sdi_s <= '0;
      end else begin
         bck_s <= {bck_s[1:0], bit_clock_in};
         wsl_s <= {wsl_s[1:0], word_select_in};
         sdi_s <= {sdi_s[0], serial_data_in};
      end
   end

   // limitation: the divider cannot reach an exact 12 MHz from 40 MHz, so the
   // generated bit clock is 20 MHz (half-period rounded down to one cycle) and the frame rate drifts
   // master clock generator; tx role bit decides who owns the clocks
   always_ff @(posedge clk) begin
      if (!reset_n || !run) begin
         div_cnt <= '0;
         bck_int <= 1'b0;
         wsl_int <= 1'b0;
         bit_pos <= '0;
      end else if (div_cnt == 4'(BCLK_HALF_CYC - 1)) begin
         div_cnt <= '0;
         bck_int <= !bck_int;
         if (bck_int) begin
            // falling edge of bit clock advances frame position
            bit_pos <= (bit_pos == frame_len(tx_config[RATE_HI:RATE_LO]) - 1'b1) ?
                       11'h0 : bit_pos + 1'b1;
            wsl_int <= (bit_pos == frame_len(tx_config[RATE_HI:RATE_LO]) - 1'b1);
         end
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // clock pins: driven only in master role and while running
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bit_clock_out   <= 1'b0;
         bit_clock_oe    <= 1'b0;
         word_select_out <= 1'b0;
         word_select_oe  <= 1'b0;
      end else begin
         bit_clock_out   <= bck_int;
         word_select_out <= wsl_int;
         bit_clock_oe    <= run && tx_config[ROLE_BIT];
         word_select_oe  <= run && tx_config[ROLE_BIT];
      end
   end

   // edges of the clock actually in use
   assign bck_now  = tx_config[ROLE_BIT] ? bck_int : bck_s[2];
   assign wsl_now  = tx_config[ROLE_BIT] ? wsl_int : wsl_s[2];
   // edges are found inside the serial engine by comparing with bck_prev; the
   // slave path reads the third synchroniser stage, so a bit clock edge is seen
   // two to three cycles late, and data comes from the second stage, which
   // keeps it inside the codec's hold window
   // limitation: a slave bit clock faster than about a sixth of clk is missed

   // serial engine: latch word select, shift on bit clock edges
   logic bck_prev;
   logic [5:0] chan_pos;
   always_ff @(posedge clk) begin
      if (!reset_n || !run) begin
         bck_prev  <= 1'b0;
         wsl_prev  <= 1'b0;
         chan_pos  <= 6'h3f;
         tx_shift  <= '0;
         rx_shift  <= '0;
         serial_data_out <= 1'b0;
         tx_pop    <= 1'b0;
         rx_push   <= 1'b0;
         rx_word   <= '0;
      end else begin
         bck_prev <= bck_now;
         tx_pop   <= 1'b0;
         rx_push  <= 1'b0;
         if (bck_now && !bck_prev) begin
            // rising bit clock: sample input and watch word select
            wsl_prev <= wsl_now;
            if (chan_pos < 6'(2 * chan_bits(rx_config[WIDTH_HI:WIDTH_LO])) &&
                rx_command[XFER_EN_BIT]) begin
               rx_shift <= {rx_shift[SAMPLE_W-2:0], sdi_s[1]};
               if (chan_pos == 6'(chan_bits(rx_config[WIDTH_HI:WIDTH_LO]) - 1) ||
                   chan_pos == 6'(2 * chan_bits(rx_config[WIDTH_HI:WIDTH_LO]) - 1)) begin
                  rx_word <= ({rx_shift[SAMPLE_W-2:0], sdi_s[1]} <<
                             (SAMPLE_W - chan_bits(rx_config[WIDTH_HI:WIDTH_LO]))) &
                             width_mask(rx_config[WIDTH_HI:WIDTH_LO]);
                  rx_push <= 1'b1;
               end
            end
            if (wsl_now && !wsl_prev) chan_pos <= '0;
            else if (chan_pos != 6'h3f) chan_pos <= chan_pos + 1'b1;
         end else if (!bck_now && bck_prev) begin
            // falling bit clock: present next transmit bit, msb first
            if (tx_command[XFER_EN_BIT] &&
                chan_pos < 6'(2 * chan_bits(tx_config[WIDTH_HI:WIDTH_LO]))) begin
               if (chan_pos == 6'h0 ||
                   chan_pos == 6'(chan_bits(tx_config[WIDTH_HI:WIDTH_LO]))) begin
                  tx_shift <= tx_empty ? '0 :
                              (tx_mem[tx_rp[PTR_W-1:0]] &
                               width_mask(tx_config[WIDTH_HI:WIDTH_LO])) << 1;
                  serial_data_out <= !tx_empty && tx_mem[tx_rp[PTR_W-1:0]][SAMPLE_W-1];
                  tx_pop <= !tx_empty;
               end else begin
                  serial_data_out <= tx_shift[SAMPLE_W-1];
                  tx_shift <= tx_shift << 1;
               end
            end else begin
               serial_data_out <= 1'b0;
            end
         end
      end
   end
endmodule // dfsp_regs
